// ---- rtl/asp_cfg.svh ----
// constants of the asynchronous serial port: offsets, field positions, resets, timing
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH
// register offsets on the plain register port
`define ASP_OFF_CTRL 3'h0
`define ASP_OFF_XMIT 3'h1
`define ASP_OFF_RX 3'h2
`define ASP_OFF_FLAGS 3'h3
`define ASP_OFF_IRQ_ST 3'h4
`define ASP_OFF_IRQ_MASK 3'h5
// serial_ctrl_reg fields
`define ASP_C_XMIT_ON 0
`define ASP_C_RX_ON 1
`define ASP_C_XE_IRQ_ON 2
`define ASP_C_XD_IRQ_ON 3
`define ASP_C_RX_IRQ_ON 4
`define ASP_C_PFS_TX 5
`define ASP_C_PFS_RX 6
`define ASP_C_GP_OUT 7
// serial_flags_reg fields; the error flags sit under mask 38h
`define ASP_F_EMPTY 7
`define ASP_F_FULL 6
`define ASP_F_OVR 5
`define ASP_F_FER 4
`define ASP_F_END 2
`define ASP_ERR_MASK 8'h38
// interrupt status / mask fields
`define ASP_I_XE 0
`define ASP_I_XD 1
`define ASP_I_RF 2
`define ASP_I_RE 3
// reset values
`define ASP_CTRL_RST 8'h80
`define ASP_MASK_RST 4'h0
// timing: peripheral clock and line rate
`define ASP_CLK_HZ 20000000
`define ASP_BAUD 57600
`endif

// ---- rtl/asp_pkg.sv ----
// types of the asynchronous serial port
package asp_pkg;
	// register port request, one cycle per access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} asp_bus_t;
	typedef enum logic [0:0] {TX_IDLE, TX_SEND} asp_tx_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_RECV} asp_rx_t;
	// whole state of the port
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] xmit;
		logic empty;
		logic empty_prev;
		asp_tx_t tx_st;
		logic [7:0] tx_sh;
		logic [15:0] tx_cnt;
		logic [3:0] tx_bit;
		logic tx_line;
		logic sync1;
		logic sync2;
		logic rx_prev;
		asp_rx_t rx_st;
		logic [7:0] rx_sh;
		logic [15:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [7:0] rx_hold;
		logic full;
		logic ovr;
		logic fer;
		logic [3:0] irq_st;
		logic [3:0] irq_mask;
		logic [7:0] rdata;
	} asp_state_t;
endpackage

// ---- rtl/asp_serial_port.sv ----
// asynchronous serial port: 8N2 transmitter and receiver with register port and interrupts
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`include "asp_cfg.svh"
module asp_serial_port #(
	parameter int CLK_HZ = `ASP_CLK_HZ,
	parameter int BAUD = `ASP_BAUD
) (
	input wire logic clk,
	input wire logic rstn,
	input asp_pkg::asp_bus_t bus,
	output logic [7:0] rdata,
	input wire logic rxd_pin,
	output logic txd_pin,
	output logic xmit_empty_irq,
	output logic xmit_done_irq,
	output logic rx_full_irq,
	output logic rx_error_irq,
	output logic irq
);
	// cycles per bit and half bit, rounded down from the clock and line rate
	// limitation: rounding down runs the line a little fast; centre sampling absorbs it
	localparam logic [15:0] BIT_CYC = 16'(CLK_HZ / BAUD);
	localparam logic [15:0] HALF_CYC = 16'(CLK_HZ / BAUD / 2);
	localparam logic [3:0] LAST_TX_BIT = 4'ha;
	localparam logic [3:0] LAST_RX_BIT = 4'h9;

	asp_pkg::asp_state_t s_reg; // registered state
	asp_pkg::asp_state_t s_next; // next state
	logic [7:0] flags; // serial_flags_reg view
	logic [3:0] req; // gated requests

	// true on the last cycle of a bit period of the given length
	function automatic logic period_end(input logic [15:0] cnt, input logic [15:0] len);
		period_end = (cnt == len - 16'h1);
	endfunction

	// status flags assembled for reads
	// transmit end is derived, never stored, so it cannot disagree with the shifter
	always_comb
	begin
		flags = 8'h00;
		flags[`ASP_F_EMPTY] = s_reg.empty;
		flags[`ASP_F_FULL] = s_reg.full;
		flags[`ASP_F_OVR] = s_reg.ovr;
		flags[`ASP_F_FER] = s_reg.fer;
		flags[`ASP_F_END] = s_reg.empty && (s_reg.tx_st == asp_pkg::TX_IDLE);
	end

	// requests: sticky status, per-request enable mask and the control enables
	// each request needs all three, so software may silence it at either level
	always_comb
	begin
		req[`ASP_I_XE] = s_reg.irq_st[`ASP_I_XE] && s_reg.ctrl[`ASP_C_XE_IRQ_ON];
		req[`ASP_I_XD] = s_reg.irq_st[`ASP_I_XD] && s_reg.ctrl[`ASP_C_XD_IRQ_ON];
		req[`ASP_I_RF] = s_reg.irq_st[`ASP_I_RF] && s_reg.ctrl[`ASP_C_RX_IRQ_ON];
		req[`ASP_I_RE] = s_reg.irq_st[`ASP_I_RE] && s_reg.ctrl[`ASP_C_RX_IRQ_ON];
		req = req & s_reg.irq_mask;
	end

	assign xmit_empty_irq = req[`ASP_I_XE];
	assign xmit_done_irq = req[`ASP_I_XD];
	assign rx_full_irq = req[`ASP_I_RF];
	assign rx_error_irq = req[`ASP_I_RE];
	assign irq = |req;
	assign rdata = s_reg.rdata;
	// pin select picks the serial line or the general-purpose level
	assign txd_pin = s_reg.ctrl[`ASP_C_PFS_TX] ? s_reg.tx_line : s_reg.ctrl[`ASP_C_GP_OUT];

	// next-state logic for bus, transmitter, receiver and interrupts
	always_comb
	begin
		logic [3:0] ev; // events of this cycle
		logic line; // receive line as seen by the receiver
		logic xe_lvl; // holding register may take a byte
		ev = 4'h0;
		line = 1'b1;
		xe_lvl = 1'b0;
		s_next = s_reg;
		// read data stand for one cycle only
		s_next.rdata = 8'h00;
		if (bus.rd)
		begin
			case (bus.addr)
				`ASP_OFF_CTRL: s_next.rdata = s_reg.ctrl;
				`ASP_OFF_XMIT: s_next.rdata = s_reg.xmit;
				`ASP_OFF_RX: s_next.rdata = s_reg.rx_hold;
				`ASP_OFF_FLAGS: s_next.rdata = flags;
				`ASP_OFF_IRQ_ST: s_next.rdata = {4'h0, s_reg.irq_st};
				`ASP_OFF_IRQ_MASK: s_next.rdata = {4'h0, s_reg.irq_mask};
				default: s_next.rdata = 8'h00;
			endcase
			// reading the received byte frees the holding register
			if (bus.addr == `ASP_OFF_RX)
				s_next.full = 1'b0;
		end
		// register writes; hardware events below override clears
		if (bus.wr)
		begin
			case (bus.addr)
				`ASP_OFF_CTRL: s_next.ctrl = bus.wdata;
				`ASP_OFF_XMIT:
				begin
					s_next.xmit = bus.wdata;
					s_next.empty = 1'b0;
				end
				`ASP_OFF_FLAGS:
				begin
					// error flags clear by writing zero to them
					s_next.ovr = s_reg.ovr && bus.wdata[`ASP_F_OVR];
					s_next.fer = s_reg.fer && bus.wdata[`ASP_F_FER];
				end
				`ASP_OFF_IRQ_ST: s_next.irq_st = s_reg.irq_st & ~bus.wdata[3:0];
				`ASP_OFF_IRQ_MASK: s_next.irq_mask = bus.wdata[3:0];
				default: ;
			endcase
		end

		// transmitter
		// a new write never shortens a frame: the holding register waits for idle
		case (s_reg.tx_st)
			asp_pkg::TX_IDLE:
			begin
				s_next.tx_line = 1'b1;
				if (s_reg.ctrl[`ASP_C_XMIT_ON] && !s_reg.empty)
				begin
					s_next.tx_sh = s_reg.xmit;
					s_next.empty = 1'b1;
					s_next.tx_st = asp_pkg::TX_SEND;
					s_next.tx_line = 1'b0;
					s_next.tx_cnt = 16'h0;
					s_next.tx_bit = 4'h0;
				end
			end
			asp_pkg::TX_SEND:
			begin
				s_next.tx_cnt = s_reg.tx_cnt + 16'h1;
				if (!s_reg.ctrl[`ASP_C_XMIT_ON])
				begin
					// transmission disabled mid-frame: abandon and idle high
					s_next.tx_st = asp_pkg::TX_IDLE;
					s_next.tx_line = 1'b1;
				end
				else if (period_end(s_reg.tx_cnt, BIT_CYC))
				begin
					s_next.tx_cnt = 16'h0;
					s_next.tx_bit = s_reg.tx_bit + 4'h1;
					if (s_reg.tx_bit < 4'h8)
					begin
						// data go out lsb first
						s_next.tx_line = s_reg.tx_sh[0];
						s_next.tx_sh = {1'b0, s_reg.tx_sh[7:1]};
					end
					else if (s_reg.tx_bit < LAST_TX_BIT)
						s_next.tx_line = 1'b1;
					else
					begin
						s_next.tx_st = asp_pkg::TX_IDLE;
						s_next.tx_line = 1'b1;
						// end of the last character when nothing waits; a byte written
						// in this very cycle goes out next, so it is not the end yet
						if (s_next.empty)
							ev[`ASP_I_XD] = 1'b1;
					end
				end
			end
			default: s_next.tx_st = asp_pkg::TX_IDLE;
		endcase
		// holding register free while transmission is on
		xe_lvl = s_reg.ctrl[`ASP_C_XMIT_ON] && s_reg.empty;
		s_next.empty_prev = xe_lvl;
		if (xe_lvl && !s_reg.empty_prev)
			ev[`ASP_I_XE] = 1'b1;

		// receiver input: two-flop synchroniser, idle high when pin not routed
		s_next.sync1 = rxd_pin;
		s_next.sync2 = s_reg.sync1;
		line = s_reg.ctrl[`ASP_C_PFS_RX] ? s_reg.sync2 : 1'b1;
		s_next.rx_prev = line;
		// only the second stop bit is judged; the first one just spaces the frame
		case (s_reg.rx_st)
			asp_pkg::RX_IDLE:
			begin
				if (s_reg.ctrl[`ASP_C_RX_ON] && s_reg.rx_prev && !line)
				begin
					s_next.rx_st = asp_pkg::RX_START;
					s_next.rx_cnt = 16'h0;
				end
			end
			asp_pkg::RX_START:
			begin
				s_next.rx_cnt = s_reg.rx_cnt + 16'h1;
				if (!s_reg.ctrl[`ASP_C_RX_ON])
					s_next.rx_st = asp_pkg::RX_IDLE;
				else if (period_end(s_reg.rx_cnt, HALF_CYC))
				begin
					// a start bit gone high at its centre was a glitch
					s_next.rx_st = line ? asp_pkg::RX_IDLE : asp_pkg::RX_RECV;
					s_next.rx_cnt = 16'h0;
					s_next.rx_bit = 4'h0;
				end
			end
			asp_pkg::RX_RECV:
			begin
				s_next.rx_cnt = s_reg.rx_cnt + 16'h1;
				if (!s_reg.ctrl[`ASP_C_RX_ON])
					s_next.rx_st = asp_pkg::RX_IDLE;
				else if (period_end(s_reg.rx_cnt, BIT_CYC))
				begin
					s_next.rx_cnt = 16'h0;
					s_next.rx_bit = s_reg.rx_bit + 4'h1;
					if (s_reg.rx_bit < 4'h8)
						s_next.rx_sh = {line, s_reg.rx_sh[7:1]};
					else if (s_reg.rx_bit == LAST_RX_BIT)
					begin
						s_next.rx_st = asp_pkg::RX_IDLE;
						if (s_reg.full)
						begin
							// previous byte unread: keep it, flag overrun
							s_next.ovr = 1'b1;
							ev[`ASP_I_RE] = 1'b1;
						end
						else if (!line)
						begin
							s_next.fer = 1'b1;
							ev[`ASP_I_RE] = 1'b1;
						end
						else
						begin
							s_next.rx_hold = s_reg.rx_sh;
							s_next.full = 1'b1;
							ev[`ASP_I_RF] = 1'b1;
						end
					end
				end
			end
			default: s_next.rx_st = asp_pkg::RX_IDLE;
		endcase
		// sticky status: a new event wins over a clear in the same cycle
		s_next.irq_st = s_next.irq_st | ev;
	end

	// state register
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			// line, synchroniser and edge history start idle high: no false start on release
			s_reg <= '0;
			s_reg.ctrl <= `ASP_CTRL_RST;
			s_reg.empty <= 1'b1;
			s_reg.tx_line <= 1'b1;
			s_reg.sync1 <= 1'b1;
			s_reg.sync2 <= 1'b1;
			s_reg.rx_prev <= 1'b1;
			s_reg.irq_mask <= `ASP_MASK_RST;
		end
		else
			s_reg <= s_next;
	end

	// checks
	// all checks share the one clock and sleep while reset is held
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence tx_start_s;
		s_reg.tx_st == asp_pkg::TX_IDLE ##1 s_reg.tx_st == asp_pkg::TX_SEND;
	endsequence

	idle_line_high_a: assert property (s_reg.tx_st == asp_pkg::TX_IDLE |-> s_reg.tx_line)
		else $error("line not high while idle");
	start_bit_low_a: assert property (tx_start_s |-> !s_reg.tx_line [*2])
		else $error("start bit not low");
	stop_bits_high_a: assert property (s_reg.tx_st == asp_pkg::TX_SEND && s_reg.tx_bit >= 4'h9
		|-> s_reg.tx_line)
		else $error("stop bit not high");
	xmit_off_idle_a: assert property (!s_reg.ctrl[`ASP_C_XMIT_ON] |=> s_reg.tx_st == asp_pkg::TX_IDLE)
		else $error("sending while transmission disabled");
	pin_select_a: assert property (!s_reg.ctrl[`ASP_C_PFS_TX] |-> txd_pin == s_reg.ctrl[`ASP_C_GP_OUT])
		else $error("pin not returned to port use");
	rx_gate_a: assert property (!s_reg.ctrl[`ASP_C_RX_IRQ_ON] |-> !rx_full_irq && !rx_error_irq)
		else $error("receive request while gated");
	rx_load_a: assert property ($rose(s_reg.irq_st[`ASP_I_RF]) |-> s_reg.full && !$past(s_reg.full))
		else $error("receive full without new byte");
	rx_err_a: assert property ($rose(s_reg.ovr) || $rose(s_reg.fer) |-> s_reg.irq_st[`ASP_I_RE]
		&& $stable(s_reg.rx_hold))
		else $error("error without request");
	done_event_a: assert property ($rose(s_reg.irq_st[`ASP_I_XD]) |-> s_reg.empty
		&& $past(s_reg.tx_bit) == LAST_TX_BIT)
		else $error("done raised early");
	start_check_a: assert property (s_reg.rx_st == asp_pkg::RX_IDLE ##1 s_reg.rx_st == asp_pkg::RX_START
		|-> $past(s_reg.rx_prev) && !s_reg.rx_prev)
		else $error("start without falling edge");

	// the empty request follows each rise of the free level by one edge
	sequence xe_rise_s;
		!(s_reg.ctrl[`ASP_C_XMIT_ON] && s_reg.empty)
			##1 (s_reg.ctrl[`ASP_C_XMIT_ON] && s_reg.empty);
	endsequence
	// an idle transmitter with a full holding register and transmission on starts a frame on the next edge
	sequence tx_load_s;
		s_reg.tx_st == asp_pkg::TX_IDLE && s_reg.ctrl[`ASP_C_XMIT_ON] && !s_reg.empty;
	endsequence
	sequence tx_frame_s;
		s_reg.tx_st == asp_pkg::TX_SEND && !s_reg.tx_line;
	endsequence

	xe_request_a: assert property (xe_rise_s |=> s_reg.irq_st[`ASP_I_XE])
		else $error("empty request missing");
	xmit_start_a: assert property (tx_load_s |=> tx_frame_s)
		else $error("frame not started");
	// counters stay below one bit time, so no bit is stretched past its length
	tx_bit_time_a: assert property (s_reg.tx_st == asp_pkg::TX_SEND
		|-> s_reg.tx_cnt < BIT_CYC)
		else $error("transmit bit too long");
	rx_bit_time_a: assert property (s_reg.rx_st == asp_pkg::RX_RECV
		|-> s_reg.rx_cnt < BIT_CYC)
		else $error("receive bit too long");
	// an errored character never raises the receive-full request as well
	err_not_full_a: assert property ($rose(s_reg.irq_st[`ASP_I_RE])
		|-> !$rose(s_reg.irq_st[`ASP_I_RF]))
		else $error("error and full raised together");
	// the holding register only ever changes with a good character
	hold_on_good_a: assert property ($changed(s_reg.rx_hold)
		|-> s_reg.irq_st[`ASP_I_RF])
		else $error("holding register changed without full");
	// a stale byte left on the read port would be taken for a fresh one
	read_pulse_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data held past its cycle");
endmodule // asp_serial_port

// ---- test/asp_peer.sv ----
// remote serial peer: sends frames into the port and decodes the frames it transmits
module asp_peer #(
	parameter int BIT = 16
) (
	input wire logic clk,
	input wire logic txd,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got_q[$]; // bytes decoded from the port's output line
	int bad = 0; // stop bits seen low on the port's output line
	initial rxd = 1'b1; // idle high between frames
	// one frame, start bit first; bad_stop pulls only the second stop low
	task automatic send(input logic [7:0] b, input logic bad_stop);
		logic [10:0] f;
		f = {~bad_stop, 1'b1, b, 1'b0};
		@(posedge clk);
		for (int i = 0; i < 11; i++)
		begin
			rxd <= f[i];
			repeat (BIT) @(posedge clk);
		end
		rxd <= 1'b1; // back to idle so the next start is a real falling edge
	endtask
	// decode at bit centres; a wrong bit time garbles the bytes or the stops
	initial
	begin : dec
		logic [7:0] d;
		forever
		begin
			@(negedge txd);
			repeat (BIT / 2) @(posedge clk);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT) @(posedge clk);
				d[i] = txd;
			end
			repeat (BIT) @(posedge clk);
			if (txd !== 1'b1)
				bad++;
			repeat (BIT) @(posedge clk);
			if (txd !== 1'b1)
				bad++;
			got_q.push_back(d);
		end
	end
endmodule // asp_peer

// ---- test/tb_asp_serial_port.sv ----
// self-checking testbench of the asynchronous serial port
`include "asp_cfg.svh"
module tb_asp_serial_port;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CLK_HZ = 50000000; // bench clock
	localparam int BAUD = 3125000; // short bit time keeps the run brief
	localparam int BIT = CLK_HZ / BAUD;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	asp_pkg::asp_bus_t bus = '0;
	logic [7:0] rdata;
	logic rxd_pin;
	logic txd_pin;
	wire [3:0] irqs; // rx error, rx full, xmit done, xmit empty
	logic irq;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [7:0] rd_v; // last read value
`define CHK(nm, exp, got) \
	begin checks_done++; if ((got) !== (exp)) begin \
	$display("MISMATCH %s expected %h seen %h", nm, exp, got); err_total++; end end
	asp_serial_port #(.CLK_HZ(CLK_HZ), .BAUD(BAUD)) dut (
		.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .rxd_pin(rxd_pin),
		.txd_pin(txd_pin), .xmit_empty_irq(irqs[0]), .xmit_done_irq(irqs[1]),
		.rx_full_irq(irqs[2]), .rx_error_irq(irqs[3]), .irq(irq)
	);
	asp_peer #(.BIT(BIT)) peer (.clk(clk), .txd(txd_pin), .rxd(rxd_pin));
	initial
	begin
		forever #10 clk = ~clk;
	end
	// hang guard: far above the roughly 1400 cycles (seven 176-cycle frames plus bus traffic) the scenarios need
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// bus cycles start at a rising edge and end at one; one idle cycle follows each
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [2:0] a);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 rd_v = rdata;
		@(posedge clk);
	endtask
	task automatic wait_irq(input int k, input logic v);
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			#1 n++;
		end
		while (irqs[k] !== v && n < 1000);
		`CHK("irq line", v, irqs[k])
		@(posedge clk);
	endtask
	// host side error handling: stop reception, clear flags and status, drop enables
	task automatic clean();
		wr(`ASP_OFF_CTRL, 8'hd0);
		wr(`ASP_OFF_FLAGS, 8'h00);
		wr(`ASP_OFF_IRQ_ST, 8'h0f);
		wr(`ASP_OFF_CTRL, 8'h80);
		rd(`ASP_OFF_FLAGS);
		`CHK("flags cleared", 8'h00, rd_v & `ASP_ERR_MASK)
		`CHK("irq idle", 1'b0, irq)
	endtask
	task automatic t_regs();
		rd(`ASP_OFF_CTRL);
		`CHK("ctrl reset", 8'h80, rd_v)
		rd(`ASP_OFF_IRQ_MASK);
		`CHK("mask reset", 8'h00, rd_v)
		wr(3'h6, 8'h00);
		rd(3'h7);
		`CHK("unmapped read", 8'h00, rd_v)
		rd(`ASP_OFF_CTRL);
		`CHK("ctrl kept", 8'h80, rd_v)
	endtask
	// two bytes refilled on the empty request, then wait for the end request
	task automatic t_tx();
		wr(`ASP_OFF_IRQ_MASK, 8'h0f);
		wr(`ASP_OFF_IRQ_ST, 8'h0f);
		wr(`ASP_OFF_CTRL, 8'ha5);
		wait_irq(0, 1'b1);
		wr(`ASP_OFF_IRQ_ST, 8'h01);
		wr(`ASP_OFF_XMIT, 8'h4b);
		wait_irq(0, 1'b1);
		wr(`ASP_OFF_IRQ_ST, 8'h01);
		wr(`ASP_OFF_XMIT, 8'hd2);
		wr(`ASP_OFF_CTRL, 8'ha9);
		`CHK("empty gated", 1'b0, irqs[0])
		`CHK("done early", 1'b0, irqs[1])
		wait_irq(1, 1'b1);
		`CHK("frames out", 2, peer.got_q.size())
		`CHK("byte one", 8'h4b, peer.got_q[0])
		`CHK("byte two", 8'hd2, peer.got_q[1])
		`CHK("stop bits", 0, peer.bad)
		`CHK("idle high", 1'b1, txd_pin)
		wr(`ASP_OFF_CTRL, 8'h89);
		wr(`ASP_OFF_CTRL, 8'h80);
		wr(`ASP_OFF_IRQ_ST, 8'h0f);
		`CHK("done cleared", 1'b0, irqs[1])
		wr(`ASP_OFF_CTRL, 8'ha0);
		wr(`ASP_OFF_XMIT, 8'h00);
		repeat (2 * BIT) @(posedge clk);
		#1 `CHK("no send when off", 1'b1, txd_pin)
		`CHK("no frame when off", 2, peer.got_q.size())
		@(posedge clk);
	endtask
	task automatic t_rx_good();
		wr(`ASP_OFF_FLAGS, 8'h00);
		wr(`ASP_OFF_CTRL, 8'hd2);
		peer.send(8'h3c, 1'b0);
		wait_irq(2, 1'b1);
		`CHK("no error", 1'b0, irqs[3])
		rd(`ASP_OFF_RX);
		`CHK("rx byte", 8'h3c, rd_v)
		wr(`ASP_OFF_IRQ_ST, 8'h04);
		`CHK("full cleared", 1'b0, irqs[2])
		wr(`ASP_OFF_CTRL, 8'hc0);
		peer.send(8'h5a, 1'b0);
		rd(`ASP_OFF_IRQ_ST);
		`CHK("rx off", 8'h00, rd_v)
	endtask
	// second byte lands before the first is read
	task automatic t_rx_ovr();
		wr(`ASP_OFF_CTRL, 8'hc2);
		peer.send(8'h11, 1'b0);
		repeat (BIT) @(posedge clk);
		`CHK("gated full", 1'b0, irqs[2])
		wr(`ASP_OFF_CTRL, 8'hd2);
		`CHK("ungated full", 1'b1, irqs[2])
		peer.send(8'h22, 1'b0);
		wait_irq(3, 1'b1);
		rd(`ASP_OFF_FLAGS);
		`CHK("overrun flag", 8'h20, rd_v & `ASP_ERR_MASK)
		rd(`ASP_OFF_RX);
		`CHK("kept byte", 8'h11, rd_v)
		clean();
	endtask
	task automatic t_rx_fer();
		wr(`ASP_OFF_CTRL, 8'hd2);
		peer.send(8'h55, 1'b1);
		wait_irq(3, 1'b1);
		`CHK("no full", 1'b0, irqs[2])
		rd(`ASP_OFF_FLAGS);
		`CHK("framing flag", 8'h10, rd_v & `ASP_ERR_MASK)
		wr(`ASP_OFF_IRQ_MASK, 8'h00);
		`CHK("masked", 1'b0, irq)
		wr(`ASP_OFF_IRQ_MASK, 8'h0f);
		`CHK("unmasked", 1'b1, irq)
		rd(`ASP_OFF_RX);
		clean();
	endtask
	// last: a low port level looks like a start bit to the peer
	task automatic t_pin();
		wr(`ASP_OFF_CTRL, 8'h00);
		`CHK("port low", 1'b0, txd_pin)
		wr(`ASP_OFF_CTRL, 8'h80);
		`CHK("port high", 1'b1, txd_pin)
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		#1 `CHK("txd in reset", 1'b1, txd_pin)
		`CHK("irq in reset", 1'b0, irq)
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_tx();
		t_rx_good();
		t_rx_ovr();
		t_rx_fer();
		t_pin();
		stop_test();
	end
endmodule // tb_asp_serial_port
